// File: rtl/banked_data_eeprom_controller.sv
// Bank select register, extra RAM page and nonvolatile page controller.
// Assumes the core presents one byte access per cycle on the data space.
//
// Summary of operation
// - Bank bit 4 maps RAM page 2; bit 0 maps the NVM page.
// - Bank select at E8h takes byte writes only; never read back.
// - Addresses 00h-3Fh go to the selected bank, low six bits as offset.
// - Bank select not cleared at reset; software writes it first.
// - Bank select is untouched by interrupts or calls.
// - Standby powers the NVM down; accesses are meaningless.
// - No bank selected means paged accesses are meaningless.
// - Busy flag set during programming; accesses aborted, cycle completes.
// - Control writes ignored while busy; only busy status readable.
// - Idle, awake NVM reads behave exactly like RAM reads.
// - Without write enable, NVM writes start no programming.
// - Byte mode writes program the addressed byte directly.
// - Arming row mode clears eight latches; writes then fill them.
// - A row shares A5-A3; A2-A0 pick the byte.
// - Armed row mode exposes only the latched row; no reads then.
// - Row start programs only bytes written since arming.
// - Row start sets only with enable and arm already set.
// - End of row cycle clears arm and start automatically.
// - Clearing arm before start discards latches unprogrammed.
// - A stop instruction disables the NVM at once.
// - Control register resets to 00h; bits 4 and 5 reserved.
`timescale 1ns/1ps
`default_nettype none
module banked_data_eeprom_controller
  import nvm_bank_pkg::*;
#(
  parameter int PROG_CYCLES = nvm_bank_pkg::PROG_CYCLES_DEF
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] addr,
  input  wire logic       rd_en,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       stop_exec,
  output logic      [7:0] rd_data,
  output logic            rd_valid,
  output logic            nvm_busy_flag,
  output logic            nvm_standby
);
  import nvm_bank_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BYTE = 2'b01,
    ST_ROW  = 2'b10
  } prog_state_t;

  typedef struct packed {
    prog_state_t             state;
    logic [15:0]             count;
    logic [7:0]              bank;
    logic                    standby;
    logic                    row_start;
    logic                    row_arm;
    logic                    write_en;
    logic                    row_locked;
    logic [PAGE_AW-1:ROW_AW] row_addr;
    logic [ROW_BYTES-1:0]    row_touched;
    logic [ROW_BYTES*8-1:0]  row_data;
    logic [PAGE_AW-1:0]      byte_addr;
    logic [7:0]              byte_data;
    logic [7:0]              rd_data;
    logic                    rd_valid;
    logic                    prog_busy;
  } ctl_state_t;

  localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);

  ctl_state_t st_reg;
  ctl_state_t st_next;

  logic [7:0]         ram_page [2**PAGE_AW];
  logic [7:0]         nvm_rd;
  logic               cell_we;
  logic [PAGE_AW-1:0] cell_waddr;
  logic [7:0]         cell_wdata;
  logic [ROW_AW-1:0]  row_idx;

  logic paged;
  logic ram_sel;
  logic nvm_sel;
  logic busy;
  logic ctl_wr;

  assign paged   = addr <= PAGED_LAST_ADDR;
  assign ram_sel = st_reg.bank[RAM_PAGE2_BIT];
  assign nvm_sel = st_reg.bank[NVM_PAGE0_BIT];
  assign busy    = st_reg.prog_busy;
  assign ctl_wr  = wr_en && addr == NVM_CONTROL_ADDR;

  nvm_cell_array #(
    .AW (PAGE_AW)
  ) u_cells (
    .clk     (clk),
    .rd_addr (addr[PAGE_AW-1:0]),
    .rd_data (nvm_rd),
    .wr_en   (cell_we),
    .wr_addr (cell_waddr),
    .wr_data (cell_wdata)
  );

  // Extra RAM page; several pages selected together just AND on reads
  always_ff @(posedge clk) begin
    if (wr_en && paged && ram_sel) begin
      ram_page[addr[PAGE_AW-1:0]] <= wr_data;
    end
  end

  always_comb begin
    logic [7:0] rd_mux;
    rd_mux  = ERASED_BYTE;
    st_next = st_reg;
    st_next.rd_valid = rd_en;
    cell_we    = 1'b0;
    cell_waddr = st_reg.byte_addr;
    cell_wdata = st_reg.byte_data;
    row_idx    = st_reg.count[ROW_AW-1:0];

    // Bank select: write only, unaffected by anything but a byte write
    if (wr_en && addr == BANK_SELECT_ADDR) begin
      st_next.bank = wr_data;
    end

    // Read mux: overlapping pages corrupt each other, as software is warned
    if (rd_en) begin
      if (addr == NVM_CONTROL_ADDR) begin
        rd_mux = 8'h00;
        rd_mux[BUSY_BIT] = busy;
      end else if (paged) begin
        if (ram_sel) begin
          rd_mux = rd_mux & ram_page[addr[PAGE_AW-1:0]];
        end
        // Standby, busy or armed row give no valid data
        if (nvm_sel) begin
          if (!st_reg.standby && !busy && !st_reg.row_arm) begin
            rd_mux = rd_mux & nvm_rd;
          end else begin
            rd_mux = 8'h00;
          end
        end
        if (!ram_sel && !nvm_sel) begin
          rd_mux = 8'h00;
        end
      end else begin
        rd_mux = 8'h00;
      end
    end
    st_next.rd_data = rd_en ? rd_mux : st_reg.rd_data;

    // Control register writes, ignored while a cycle runs
    if (ctl_wr && !busy) begin
      st_next.standby  = wr_data[STANDBY_BIT];
      st_next.write_en = wr_data[WRITE_EN_BIT];
      st_next.row_arm  = wr_data[ROW_ARM_BIT];
      if (wr_data[ROW_ARM_BIT] && !st_reg.row_arm) begin
        st_next.row_touched = '0;
        st_next.row_data    = '0;
        st_next.row_locked  = 1'b0;
      end
      if (!wr_data[ROW_ARM_BIT]) begin
        st_next.row_touched = '0;
        st_next.row_locked  = 1'b0;
      end
      if (wr_data[ROW_START_BIT] && st_reg.write_en && st_reg.row_arm
          && wr_data[ROW_ARM_BIT] && wr_data[WRITE_EN_BIT]) begin
        st_next.row_start = 1'b1;
        st_next.state     = ST_ROW;
        st_next.count     = '0;
      end
    end

    // Writes into the NVM page; aborted in standby or while busy
    if (wr_en && paged && nvm_sel && !st_reg.standby && !busy) begin
      if (st_reg.row_arm) begin
        if (!st_reg.row_locked
            || st_reg.row_addr == addr[PAGE_AW-1:ROW_AW]) begin
          st_next.row_locked = 1'b1;
          st_next.row_addr   = addr[PAGE_AW-1:ROW_AW];
          st_next.row_touched[addr[ROW_AW-1:0]] = 1'b1;
          st_next.row_data[addr[ROW_AW-1:0]*8 +: 8] = wr_data;
        end
      end else if (st_reg.write_en) begin
        st_next.state     = ST_BYTE;
        st_next.count     = '0;
        st_next.byte_addr = addr[PAGE_AW-1:0];
        st_next.byte_data = wr_data;
      end
    end

    // Programming timer; byte cells commit in the final clock, row cells in the first eight
    case (st_reg.state)
      ST_IDLE: begin
      end
      ST_BYTE: begin
        st_next.count = st_reg.count + 16'h0001;
        if (st_reg.count == PROG_LAST) begin
          cell_we       = 1'b1;
          st_next.state = ST_IDLE;
          st_next.count = '0;
        end
      end
      ST_ROW: begin
        // The row is written out a byte per clock early in the cycle
        if (st_reg.count < 16'(ROW_BYTES)
            && st_reg.row_touched[row_idx]) begin
          cell_we    = 1'b1;
          cell_waddr = {st_reg.row_addr, row_idx};
          cell_wdata = st_reg.row_data[row_idx*8 +: 8];
        end
        st_next.count = st_reg.count + 16'h0001;
        if (st_reg.count == PROG_LAST) begin
          st_next.state       = ST_IDLE;
          st_next.count       = '0;
          st_next.row_arm     = 1'b0;
          st_next.row_start   = 1'b0;
          st_next.row_touched = '0;
          st_next.row_locked  = 1'b0;
        end
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase

    // Stop forces standby at once; any running cycle still completes
    if (stop_exec) begin
      st_next.standby = 1'b1;
    end

    // Busy is a flop of its own so the status pin carries no state decode
    st_next.prog_busy = st_next.state != ST_IDLE;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg.state       <= ST_IDLE;
      st_reg.count       <= '0;
      st_reg.prog_busy   <= 1'b0;
      st_reg.standby     <= NVM_CONTROL_RST[STANDBY_BIT];
      st_reg.row_start   <= NVM_CONTROL_RST[ROW_START_BIT];
      st_reg.row_arm     <= NVM_CONTROL_RST[ROW_ARM_BIT];
      st_reg.write_en    <= NVM_CONTROL_RST[WRITE_EN_BIT];
      st_reg.row_locked  <= 1'b0;
      st_reg.row_addr    <= '0;
      st_reg.row_touched <= '0;
      st_reg.row_data    <= '0;
      st_reg.byte_addr   <= '0;
      st_reg.byte_data   <= '0;
      st_reg.rd_data     <= '0;
      st_reg.rd_valid    <= 1'b0;
      st_reg.bank        <= st_next.bank;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data       = st_reg.rd_data;
  assign rd_valid      = st_reg.rd_valid;
  assign nvm_busy_flag = busy;
  assign nvm_standby   = st_reg.standby;

  a_busy_length: assert property (@(posedge clk) disable iff (srst)
    $rose(busy) |-> busy [*8] ##0 (st_reg.count == 16'h0007 || !busy))
    else $error("busy dropped early");
  a_ctl_ignored: assert property (@(posedge clk) disable iff (srst)
    busy && ctl_wr && st_reg.state != ST_IDLE && st_reg.count != PROG_LAST
    |=> $stable(st_reg.write_en) && $stable(st_reg.standby))
    else $error("control changed while busy");
  a_no_enable: assert property (@(posedge clk) disable iff (srst)
    !busy && !st_reg.write_en && !ctl_wr |=> st_reg.state != ST_BYTE)
    else $error("byte cycle without enable");
  a_row_clear: assert property (@(posedge clk) disable iff (srst)
    st_reg.state == ST_ROW && st_reg.count == PROG_LAST
    |=> !st_reg.row_arm && !st_reg.row_start && !busy)
    else $error("row bits not cleared");
  a_start_gate: assert property (@(posedge clk) disable iff (srst)
    $rose(st_reg.row_start) |-> $past(st_reg.row_arm)
    && $past(st_reg.write_en))
    else $error("start set without arm");
  a_stop_off: assert property (@(posedge clk) disable iff (srst)
    stop_exec |=> nvm_standby)
    else $error("stop did not disable");
  a_no_bank: assert property (@(posedge clk) disable iff (srst)
    rd_en && paged && st_reg.bank == 8'h00 |=> rd_data == 8'h00)
    else $error("unselected read gave data");
  a_arm_clears: assert property (@(posedge clk) disable iff (srst)
    ctl_wr && !busy && wr_data[ROW_ARM_BIT] && !st_reg.row_arm
    |=> st_reg.row_touched == '0)
    else $error("latches not cleared");

  // Busy must end exactly on the last programmed count
  a_busy_exact: assert property (@(posedge clk) disable iff (srst)
    $fell(busy) |-> $past(st_reg.count) == PROG_LAST)
    else $error("busy length differs from parameter");

  // Register reads: control shows busy only, bank select reads as zero
  a_ctl_status: assert property (@(posedge clk) disable iff (srst)
    rd_en && addr == NVM_CONTROL_ADDR
    |=> rd_data == {6'h00, $past(busy), 1'b0})
    else $error("control read not busy only");
  a_bank_hidden: assert property (@(posedge clk) disable iff (srst)
    rd_en && addr == BANK_SELECT_ADDR |=> rd_data == 8'h00)
    else $error("bank select read back");

  // Read answers keep plain RAM timing
  a_read_timing: assert property (@(posedge clk) disable iff (srst)
    rd_en |=> rd_valid)
    else $error("read answer late");
  a_valid_single: assert property (@(posedge clk) disable iff (srst)
    !rd_en |=> !rd_valid)
    else $error("read valid without request");

  // Paged reads with no valid source must answer zero
  a_stby_reads: assert property (@(posedge clk) disable iff (srst)
    rd_en && paged && nvm_sel && st_reg.standby |=> rd_data == 8'h00)
    else $error("standby read gave data");
  a_busy_reads: assert property (@(posedge clk) disable iff (srst)
    rd_en && paged && nvm_sel && busy |=> rd_data == 8'h00)
    else $error("busy read gave data");
  a_armed_reads: assert property (@(posedge clk) disable iff (srst)
    rd_en && paged && nvm_sel && st_reg.row_arm |=> rd_data == 8'h00)
    else $error("armed read gave data");

  // Writes that must never start a programming cycle
  a_stby_no_prog: assert property (@(posedge clk) disable iff (srst)
    wr_en && paged && st_reg.standby && !busy |=> !busy)
    else $error("write in standby programmed");
  a_nobank_write: assert property (@(posedge clk) disable iff (srst)
    wr_en && paged && !nvm_sel && !busy |=> !busy)
    else $error("write without page programmed");
  a_disarm_stop: assert property (@(posedge clk) disable iff (srst)
    ctl_wr && !busy && !wr_data[ROW_ARM_BIT] |=> st_reg.state != ST_ROW)
    else $error("row cycle after disarm");

  // A locked row ignores writes that fall in another row
  a_row_lock: assert property (@(posedge clk) disable iff (srst)
    wr_en && paged && st_reg.row_arm && st_reg.row_locked
    && addr[PAGE_AW-1:ROW_AW] != st_reg.row_addr
    |=> $stable(st_reg.row_data))
    else $error("other row entered latches");
endmodule
`default_nettype wire

// File: rtl/nvm_bank_pkg.sv
// Constants for the paged data-space bank select and nonvolatile controller.
// Assumes a single core clock; the core issues byte reads and writes.
package nvm_bank_pkg;
  localparam logic [7:0] BANK_SELECT_ADDR = 8'he8;
  localparam logic [7:0] NVM_CONTROL_ADDR = 8'hea;
  localparam logic [7:0] PAGED_LAST_ADDR  = 8'h3f;
  localparam logic [7:0] NVM_CONTROL_RST  = 8'h00;
  localparam int RAM_PAGE2_BIT   = 4;
  localparam int NVM_PAGE0_BIT   = 0;
  localparam int STANDBY_BIT     = 6;
  localparam int ROW_START_BIT   = 3;
  localparam int ROW_ARM_BIT     = 2;
  localparam int BUSY_BIT        = 1;
  localparam int WRITE_EN_BIT    = 0;
  localparam int PAGE_AW         = 6;
  localparam int ROW_BYTES       = 8;
  localparam int ROW_AW          = 3;
  localparam int PROG_CYCLES_DEF = 16;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
endpackage

// File: rtl/nvm_cell_array.sv
// Nonvolatile cell array model: one 64-byte page with a per-byte write port.
// Assumes the controller never writes and reads the same cycle meaningfully.
`timescale 1ns/1ps
`default_nettype none
module nvm_cell_array #(
  parameter int AW = 6
) (
  input  wire logic          clk,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data
);
  logic [7:0] cells [2**AW];

  // Cells keep content across reset, as real nonvolatile storage does
  always_ff @(posedge clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
  end

  assign rd_data = cells[rd_addr];
endmodule
`default_nettype wire

// File: tb/banked_data_eeprom_controller_test.sv
// Self-checking bench for the bank select and nonvolatile controller.
// Assumes the core model drives all requests at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module banked_data_eeprom_controller_test;
  import nvm_bank_pkg::*;
  localparam int PROG = 8;
  localparam logic [7:0] BK = BANK_SELECT_ADDR;
  localparam logic [7:0] CT = NVM_CONTROL_ADDR;
  logic       clk;
  logic       srst;
  logic [7:0] addr;
  logic       rd_en;
  logic       wr_en;
  logic [7:0] wr_data;
  logic       stop_exec;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       busy;
  logic       standby;
  int         bad_count;
  int         cmp_count;
  core_bus_model i_core (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .addr(addr), .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data),
    .stop_exec(stop_exec));
  banked_data_eeprom_controller #(.PROG_CYCLES(PROG)) i_dut (.clk(clk),
    .srst(srst), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
    .wr_data(wr_data), .stop_exec(stop_exec), .rd_data(rd_data),
    .rd_valid(rd_valid), .nvm_busy_flag(busy), .nvm_standby(standby));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_check(string name, logic [7:0] a, logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_core.read(a, d, v);
    check({name, "_valid"}, {7'h00, v}, 8'h01);
    check(name, d, exp);
  endtask
  // Counts busy cycles; exp_n below zero skips the length compare
  task automatic wait_idle(int exp_n);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      n++;
      @(negedge clk);
    end
    if (n >= 100) begin
      bad_count++;
      close_out();
    end else if (exp_n >= 0) begin
      check("busy_len", n[7:0], exp_n[7:0]);
    end
  endtask
  initial begin
    bad_count = 0;
    cmp_count = 0;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    check("busy_rst", {7'h00, busy}, 8'h00);
    check("stby_rst", {7'h00, standby}, 8'h00);
    rd_check("ctl_rst", CT, 8'h00);
    rd_check("bank_rd", BK, 8'h00);
    i_core.write(BK, 8'h10);
    i_core.write(8'h05, 8'ha5);
    rd_check("ram_rd", 8'h05, 8'ha5);
    i_core.write(BK, 8'h01);
    i_core.write(8'h05, 8'h5a);
    check("no_en", {7'h00, busy}, 8'h00);
    i_core.write(CT, 8'h01);
    i_core.write(8'h05, 8'h3c);
    wait_idle(PROG);
    rd_check("byte_rd", 8'h05, 8'h3c);
    i_core.write(8'h18, 8'h77);
    rd_check("ctl_busy", CT, 8'h02);
    rd_check("rd_busy", 8'h18, 8'h00);
    i_core.write(CT, 8'h40);
    wait_idle(-1);
    check("ctl_ign", {7'h00, standby}, 8'h00);
    rd_check("byte2_rd", 8'h18, 8'h77);
    i_core.write(CT, 8'h05);
    i_core.write(8'h1a, 8'h11);
    i_core.write(8'h1b, 8'h22);
    i_core.write(CT, 8'h0d);
    wait_idle(PROG);
    rd_check("row_a", 8'h1a, 8'h11);
    rd_check("row_b", 8'h1b, 8'h22);
    rd_check("row_keep", 8'h18, 8'h77);
    i_core.write(8'h1c, 8'h55);
    check("disarm", {7'h00, busy}, 8'h01);
    wait_idle(PROG);
    rd_check("after_row", 8'h1c, 8'h55);
    i_core.write(CT, 8'h05);
    i_core.write(8'h18, 8'h99);
    i_core.write(CT, 8'h01);
    i_core.write(CT, 8'h09);
    check("no_start", {7'h00, busy}, 8'h00);
    rd_check("discard", 8'h18, 8'h77);
    // Row 3 locked; a write to row 0 must be dropped, reads give nothing
    i_core.write(CT, 8'h05);
    i_core.write(8'h1d, 8'h44);
    i_core.write(8'h05, 8'h66);
    rd_check("arm_rd", 8'h1d, 8'h00);
    i_core.write(CT, 8'h0d);
    i_core.write(8'h1c, 8'hee);
    wait_idle(-1);
    rd_check("row_lock", 8'h05, 8'h3c);
    rd_check("row_new", 8'h1d, 8'h44);
    rd_check("busy_wr", 8'h1c, 8'h55);
    i_core.write(CT, 8'h41);
    check("stby_on", {7'h00, standby}, 8'h01);
    rd_check("stby_rd", 8'h05, 8'h00);
    i_core.write(8'h05, 8'h11);
    check("stby_wr", {7'h00, busy}, 8'h00);
    i_core.write(CT, 8'h00);
    check("stby_off", {7'h00, standby}, 8'h00);
    rd_check("stby_keep", 8'h05, 8'h3c);
    i_core.stop();
    check("stop", {7'h00, standby}, 8'h01);
    i_core.write(CT, 8'h00);
    i_core.write(BK, 8'h00);
    rd_check("no_bank", 8'h05, 8'h00);
    i_core.write(BK, 8'h10);
    @(negedge clk);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    rd_check("bank_kept", 8'h05, 8'ha5);
    rd_check("ctl_rst2", CT, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire

// File: tb/core_bus_model.sv
// Core-side model: issues data-space byte reads and writes.
// Assumes the block samples requests on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module core_bus_model
  import nvm_bank_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic      [7:0] addr,
  output logic            rd_en,
  output logic            wr_en,
  output logic      [7:0] wr_data,
  output logic            stop_exec
);
  logic [7:0] bank_shadow;
  logic       armed;
  initial begin
    addr = 8'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wr_data = 8'h00;
    stop_exec = 1'b0;
    armed = 1'b0;
  end
  // Illegal bank values are never issued, so no page overlap occurs
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    if (a == BANK_SELECT_ADDR && ($countones(d) > 1 || armed)) return;
    @(negedge clk);
    if (a == BANK_SELECT_ADDR) bank_shadow = d;
    if (a == NVM_CONTROL_ADDR) armed = d[ROW_ARM_BIT] & ~d[ROW_START_BIT];
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    // Released lines show the inverse so stale values cannot pass
    addr = ~a;
    wr_data = ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    addr = ~a;
    d = rd_data;
    v = rd_valid;
  endtask
  task automatic stop();
    @(negedge clk);
    stop_exec = 1'b1;
    @(negedge clk);
    stop_exec = 1'b0;
  endtask
endmodule
`default_nettype wire
